// ==== rtl/rstg_raster_sync.sv ====
// Purpose: Raster sync timing generator with blanking, sync and refresh.
// Assumes: Host programs interval counts within their minimum widths.
// Notes:   Registers reached over a plain address/strobe port.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module rstg_raster_sync
   import rstg_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   output logic             hsync,
   output logic             vsync,
   output logic             blank,
   output logic             cycle_strobe,
   output logic             addr_valid,
   output logic      [15:0] refresh_addr,
   output logic             refresh_cycle,
   output logic             odd_field,
   output logic      [4:0]  pixels_per_cycle_ratio
);

   // ==========================================================
   // Register file
   logic [4:0]  ctrl_reg;
   logic [7:0]  hfp_reg;
   logic [7:0]  hsync_reg;
   logic [7:0]  hbp_reg;
   logic [7:0]  aw_reg;
   logic [9:0]  vfp_reg;
   logic [9:0]  vsync_reg;
   logic [9:0]  vbp_reg;
   logic [10:0] al_reg;

   rstg_phase_t h_phase_reg;
   rstg_phase_t v_phase_reg;
   logic [7:0]  h_cnt_reg;
   logic [10:0] v_cnt_reg;
   logic [1:0]  sub_cnt_reg;
   logic        extra_line_reg;
   logic        odd_field_reg;
   logic [15:0] refresh_cnt_reg;

   wire logic enable    = ctrl_reg[RSTG_CTRL_ENABLE_BIT];
   wire logic interlace = ctrl_reg[RSTG_CTRL_INTERLACE_BIT];
   wire logic ref_en    = ctrl_reg[RSTG_CTRL_REFRESH_BIT];
   wire logic wide_access_mode = ctrl_reg[RSTG_CTRL_WIDE_BIT];
   wire logic mixed     = ctrl_reg[RSTG_CTRL_MIXED_BIT];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_reg  <= RSTG_CTRL_RESET;
         hfp_reg   <= RSTG_HFP_RESET;
         hsync_reg <= RSTG_HSYNC_RESET;
         hbp_reg   <= RSTG_HBP_RESET;
         aw_reg    <= RSTG_AW_RESET;
         vfp_reg   <= RSTG_VFP_RESET;
         vsync_reg <= RSTG_VSYNC_RESET;
         vbp_reg   <= RSTG_VBP_RESET;
         al_reg    <= RSTG_AL_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            RSTG_ADDR_CTRL:  ctrl_reg  <= reg_wdata[4:0];
            RSTG_ADDR_HFP:   hfp_reg   <= reg_wdata[7:0];
            RSTG_ADDR_HSYNC: hsync_reg <= reg_wdata[7:0];
            RSTG_ADDR_HBP:   hbp_reg   <= reg_wdata[7:0];
            RSTG_ADDR_AW:    aw_reg    <= reg_wdata[7:0];
            RSTG_ADDR_VFP:   vfp_reg   <= reg_wdata[9:0];
            RSTG_ADDR_VSYNC: vsync_reg <= reg_wdata[9:0];
            RSTG_ADDR_VBP:   vbp_reg   <= reg_wdata[9:0];
            RSTG_ADDR_AL:    al_reg    <= reg_wdata[10:0];
            default: ;
         endcase
      end
   end

   // Reads answer in the next cycle only; unmapped offsets read zero.
   always_ff @(posedge core_clk) begin
      if (rst || !reg_rd) begin
         reg_rdata <= 16'h0000;
      end else begin
         case (reg_addr)
            RSTG_ADDR_CTRL:    reg_rdata <= {11'h000, ctrl_reg};
            RSTG_ADDR_HFP:     reg_rdata <= {8'h00, hfp_reg};
            RSTG_ADDR_HSYNC:   reg_rdata <= {8'h00, hsync_reg};
            RSTG_ADDR_HBP:     reg_rdata <= {8'h00, hbp_reg};
            RSTG_ADDR_AW:      reg_rdata <= {8'h00, aw_reg};
            RSTG_ADDR_VFP:     reg_rdata <= {6'h00, vfp_reg};
            RSTG_ADDR_VSYNC:   reg_rdata <= {6'h00, vsync_reg};
            RSTG_ADDR_VBP:     reg_rdata <= {6'h00, vbp_reg};
            RSTG_ADDR_AL:      reg_rdata <= {5'h00, al_reg};
            RSTG_ADDR_STATUS:  reg_rdata <= {odd_field_reg, extra_line_reg,
                                             1'b0, blank, vsync, hsync,
                                             v_phase_reg, h_phase_reg,
                                             h_cnt_reg[5:0]};
            RSTG_ADDR_REFRESH: reg_rdata <= refresh_cnt_reg;
            default:           reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ==========================================================
   // Display cycle timing
   // Mixed mode stretches only horizontal active phase cycles, on every line including vertically blanked ones, to four clocks.
   logic       cycle_end;
   logic       line_end;
   logic       h_last;
   logic [1:0] sub_last;

   always_comb begin
      sub_last = 2'(RSTG_CLKS_PER_CYCLE_NORMAL - 3'h1);
      if (mixed && h_phase_reg == RSTG_H_ACTIVE) begin
         sub_last = 2'(RSTG_CLKS_PER_CYCLE_MIXED - 3'h1);
      end
   end

   assign cycle_end = enable && (sub_cnt_reg == sub_last);

   always_ff @(posedge core_clk) begin
      if (rst || !enable || cycle_end) begin
         sub_cnt_reg <= 2'h0;
      end else begin
         sub_cnt_reg <= sub_cnt_reg + 2'h1;
      end
   end

   function automatic logic [7:0] h_len(input rstg_phase_t p,
                                        input logic [7:0] fp,
                                        input logic [7:0] sw,
                                        input logic [7:0] bp,
                                        input logic [7:0] aw);
      case (p)
         RSTG_H_FRONT: h_len = fp;
         RSTG_H_SYNC:  h_len = sw;
         RSTG_H_BACK:  h_len = bp;
         default:      h_len = aw;
      endcase
   endfunction

   assign h_last   = (h_cnt_reg + 8'h01) >= h_len(h_phase_reg, hfp_reg,
                                                   hsync_reg, hbp_reg, aw_reg);
   assign line_end = cycle_end && h_last && h_phase_reg == RSTG_H_ACTIVE;

   // ==========================================================
   // Horizontal sequencer
   always_ff @(posedge core_clk) begin
      if (rst || !enable) begin
         h_phase_reg <= RSTG_H_FRONT;
         h_cnt_reg   <= 8'h00;
      end else if (cycle_end) begin
         if (h_last) begin
            h_cnt_reg <= 8'h00;
            case (h_phase_reg)
               RSTG_H_FRONT: h_phase_reg <= RSTG_H_SYNC;
               RSTG_H_SYNC:  h_phase_reg <= RSTG_H_BACK;
               RSTG_H_BACK:  h_phase_reg <= RSTG_H_ACTIVE;
               RSTG_H_ACTIVE: h_phase_reg <= RSTG_H_FRONT;
               default:      h_phase_reg <= RSTG_H_FRONT;
            endcase
         end else begin
            h_cnt_reg <= h_cnt_reg + 8'h01;
         end
      end
   end

   // ==========================================================
   // Vertical sequencer
   // The extra interlace line is appended to the back porch of the
   // second field only, so a frame of two fields has an odd total.
   logic        v_last;
   logic [10:0] v_len;

   always_comb begin
      case (v_phase_reg)
         RSTG_H_FRONT: v_len = {1'b0, vfp_reg};
         RSTG_H_SYNC:  v_len = {1'b0, vsync_reg};
         RSTG_H_BACK:  v_len = {1'b0, vbp_reg} +
                               {10'h000, interlace && odd_field_reg};
         default:      v_len = al_reg;
      endcase
   end

   assign v_last = (v_cnt_reg + 11'h001) >= v_len;

   always_ff @(posedge core_clk) begin
      if (rst || !enable) begin
         v_phase_reg   <= RSTG_H_FRONT;
         v_cnt_reg     <= 11'h000;
         odd_field_reg <= 1'b0;
      end else if (line_end) begin
         if (v_last) begin
            v_cnt_reg <= 11'h000;
            case (v_phase_reg)
               RSTG_H_FRONT: v_phase_reg <= RSTG_H_SYNC;
               RSTG_H_SYNC:  v_phase_reg <= RSTG_H_BACK;
               RSTG_H_BACK:  v_phase_reg <= RSTG_H_ACTIVE;
               RSTG_H_ACTIVE: begin
                  v_phase_reg   <= RSTG_H_FRONT;
                  odd_field_reg <= interlace && !odd_field_reg;
               end
               default:      v_phase_reg <= RSTG_H_FRONT;
            endcase
         end else begin
            v_cnt_reg <= v_cnt_reg + 11'h001;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         extra_line_reg <= 1'b0;
      end else begin
         extra_line_reg <= interlace && odd_field_reg &&
                           v_phase_reg == RSTG_H_BACK;
      end
   end

   // ==========================================================
   // Refresh counter
   // Refresh owns every sync cycle outright; nothing else can claim it.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         refresh_cnt_reg <= 16'h0000;
      end else if (ref_en && cycle_end && h_phase_reg == RSTG_H_SYNC) begin
         refresh_cnt_reg <= refresh_cnt_reg + 16'h0001;
      end
   end

   // ==========================================================
   // Outputs, registered
   logic active_now;
   assign active_now = enable && h_phase_reg == RSTG_H_ACTIVE &&
                       v_phase_reg == RSTG_H_ACTIVE;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hsync         <= 1'b0;
         vsync         <= 1'b0;
         blank         <= 1'b1;
         cycle_strobe  <= 1'b0;
         addr_valid    <= 1'b0;
         refresh_cycle <= 1'b0;
         refresh_addr  <= 16'h0000;
         odd_field     <= 1'b0;
      end else begin
         hsync <= enable && h_phase_reg == RSTG_H_SYNC;
         vsync <= enable && v_phase_reg == RSTG_H_SYNC;
         blank <= !active_now;
         cycle_strobe <= cycle_end;
         // Mixed mode: address offered each two clocks, so twice per word.
         addr_valid <= active_now && sub_cnt_reg[0];
         refresh_cycle <= ref_en && enable &&
                          h_phase_reg == RSTG_H_SYNC;
         refresh_addr <= refresh_cnt_reg;
         odd_field <= odd_field_reg;
      end
   end

   // Pixel clock ratio to the controller clock for the external shifter.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pixels_per_cycle_ratio <= RSTG_RATIO_NORMAL;
      end else if (wide_access_mode) begin
         pixels_per_cycle_ratio <= RSTG_RATIO_WIDE;
      end else if (mixed) begin
         pixels_per_cycle_ratio <= RSTG_RATIO_MIXED;
      end else begin
         pixels_per_cycle_ratio <= RSTG_RATIO_NORMAL;
      end
   end

endmodule

// ==== rtl/rstg_pkg.sv ====
// Purpose: Shared constants for the raster sync timing generator.
// Assumes: One controller clock at 40 MHz, synchronous active-high reset.
// Notes:   Register offsets are word indices on the plain register port.
package rstg_pkg;

   // ==========================================================
   // Register map
   localparam logic [3:0] RSTG_ADDR_CTRL     = 4'h0;
   localparam logic [3:0] RSTG_ADDR_HFP      = 4'h1;
   localparam logic [3:0] RSTG_ADDR_HSYNC    = 4'h2;
   localparam logic [3:0] RSTG_ADDR_HBP      = 4'h3;
   localparam logic [3:0] RSTG_ADDR_AW       = 4'h4;
   localparam logic [3:0] RSTG_ADDR_VFP      = 4'h5;
   localparam logic [3:0] RSTG_ADDR_VSYNC    = 4'h6;
   localparam logic [3:0] RSTG_ADDR_VBP      = 4'h7;
   localparam logic [3:0] RSTG_ADDR_AL       = 4'h8;
   localparam logic [3:0] RSTG_ADDR_STATUS   = 4'h9;
   localparam logic [3:0] RSTG_ADDR_REFRESH  = 4'hA;

   // ==========================================================
   // Control register fields
   localparam int RSTG_CTRL_ENABLE_BIT    = 0;
   localparam int RSTG_CTRL_INTERLACE_BIT = 1;
   localparam int RSTG_CTRL_REFRESH_BIT   = 2;
   localparam int RSTG_CTRL_WIDE_BIT      = 3;
   localparam int RSTG_CTRL_MIXED_BIT     = 4;

   // ==========================================================
   // Reset values
   localparam logic [4:0]  RSTG_CTRL_RESET  = 5'h00;
   localparam logic [7:0]  RSTG_HFP_RESET   = 8'h02;
   localparam logic [7:0]  RSTG_HSYNC_RESET = 8'h02;
   localparam logic [7:0]  RSTG_HBP_RESET   = 8'h03;
   localparam logic [7:0]  RSTG_AW_RESET    = 8'h20;
   localparam logic [9:0]  RSTG_VFP_RESET   = 10'h001;
   localparam logic [9:0]  RSTG_VSYNC_RESET = 10'h001;
   localparam logic [9:0]  RSTG_VBP_RESET   = 10'h001;
   localparam logic [10:0] RSTG_AL_RESET    = 11'h010;

   // ==========================================================
   // Clock ratios in controller clocks per display cycle
   localparam logic [2:0] RSTG_CLKS_PER_CYCLE_NORMAL = 3'h2;
   localparam logic [2:0] RSTG_CLKS_PER_CYCLE_MIXED  = 3'h4;

   // ==========================================================
   // Pixel clock to controller clock ratio per mode
   localparam logic [4:0] RSTG_RATIO_NORMAL = 5'h08;
   localparam logic [4:0] RSTG_RATIO_WIDE   = 5'h10;
   localparam logic [4:0] RSTG_RATIO_MIXED  = 5'h04;
   localparam int RSTG_PIX_PER_WORD_NORMAL = 16;
   localparam int RSTG_PIX_PER_WORD_WIDE   = 32;

   typedef enum logic [1:0] {
      RSTG_H_FRONT,
      RSTG_H_SYNC,
      RSTG_H_BACK,
      RSTG_H_ACTIVE
   } rstg_phase_t;

endpackage

// ==== test/rstg_sync_monitor.sv ====
// Purpose: Concurrent checks on the raster sync generator ports.
// Assumes: Host keeps sync at least two and back porch at least three.
// Notes:   Bound to every instance of the generator.
`timescale 1ns/100ps
module rstg_sync_monitor (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        hsync,
   input wire logic        vsync,
   input wire logic        blank,
   input wire logic        cycle_strobe,
   input wire logic        addr_valid,
   input wire logic [15:0] refresh_addr,
   input wire logic        refresh_cycle,
   input wire logic        odd_field,
   input wire logic [4:0]  pixels_per_cycle_ratio
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read answer");
   a_hsync_blanked: assert property (hsync |-> blank)
      else $error("hsync outside blanking");
   a_vsync_blanked: assert property (vsync |-> blank)
      else $error("vsync line not blanked");
   a_refresh_in_sync: assert property (refresh_cycle |-> hsync)
      else $error("refresh outside horizontal sync");
   a_refresh_whole_run: assert property
      ($rose(refresh_cycle) |-> refresh_cycle [*4])
      else $error("refresh run cut short");
   a_cycle_two_clk: assert property
      (cycle_strobe |=> !cycle_strobe)
      else $error("display cycle shorter than two clocks");
   a_back_porch_blank: assert property
      ($fell(hsync) |-> blank [*6])
      else $error("back porch not blanked");
   a_front_porch_blank: assert property
      ($rose(hsync) |-> $past(blank, 4))
      else $error("front porch not blanked");
   a_vsync_in_retrace: assert property
      ($changed(vsync) |-> blank && !hsync)
      else $error("vsync edge outside front porch");

   cover property ($rose(vsync));
   cover property ($rose(odd_field));
   cover property ($rose(refresh_cycle));
endmodule

bind rstg_raster_sync rstg_sync_monitor u_mon (
   .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .hsync, .vsync, .blank, .cycle_strobe, .addr_valid, .refresh_addr,
   .refresh_cycle, .odd_field, .pixels_per_cycle_ratio
);

// ==== test/rstg_crt_model.sv ====
// Purpose: Monitor and shift logic model measuring the raster it receives.
// Assumes: Measurements are read after several whole fields.
// Notes:   Each figure except n_vs holds the last complete interval seen.
`timescale 1ns/100ps
module rstg_crt_model (
   input wire logic        core_clk,
   input wire logic        hsync,
   input wire logic        vsync,
   input wire logic        blank,
   input wire logic        addr_valid,
   input wire logic [15:0] refresh_addr,
   output int              hs_clks,
   output int              lo_clks,
   output int              line_clks,
   output int              vs_clks,
   output int              frame_clks,
   output int              av_cnt,
   output int              act_lines,
   output int              ref_step,
   output int              n_vs
);
   logic       hs_d = 1'b0, vs_d = 1'b0, bl_d = 1'b1;
   int         hs_r = 0, lo_r = 0, ln_r = 0, vs_r = 0;
   int         fl_r = 0, fl_p = 0, av_r = 0, al_r = 0;
   logic [15:0] ref_p = 16'h0000;

   // ==========================================================
   // Widths latch on the closing edge, periods on the opening one.
   always @(posedge core_clk) begin
      hs_d <= hsync;
      vs_d <= vsync;
      bl_d <= blank;
      hs_r <= hsync ? hs_r + 1 : 0;
      lo_r <= blank ? 0 : lo_r + 1;
      av_r <= blank ? 0 : av_r + int'(addr_valid);
      vs_r <= vsync ? vs_r + 1 : 0;
      if (hs_d && !hsync) hs_clks <= hs_r;
      // Address pulses are totalled per unblanked run, so the figure
      // does not depend on where in the field it is read.
      if (!bl_d && blank) begin
         lo_clks <= lo_r;
         av_cnt <= av_r;
      end
      if (vs_d && !vsync) vs_clks <= vs_r;
      if (bl_d && !blank) al_r <= al_r + 1;
      if (hsync && !hs_d) begin
         line_clks <= ln_r;
         ln_r <= 1;
         ref_step <= int'(16'(refresh_addr - ref_p));
         ref_p <= refresh_addr;
      end else begin
         ln_r <= ln_r + 1;
      end
      if (vsync && !vs_d) begin
         frame_clks <= fl_r + fl_p;
         fl_p <= fl_r;
         fl_r <= 1;
         act_lines <= al_r;
         al_r <= 0;
         n_vs <= n_vs + 1;
      end else begin
         fl_r <= fl_r + 1;
      end
   end
endmodule

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the raster sync generator.
// Assumes: Registers reached over the plain strobe port.
// Notes:   Each mode runs from a fresh reset with random intervals.
`timescale 1ns/100ps
module testbench;
   import rstg_pkg::*;
   logic        core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, refresh_addr;
   logic        hsync, vsync, blank, cycle_strobe, addr_valid;
   logic        refresh_cycle, odd_field;
   logic [4:0]  pixels_per_cycle_ratio;
   int          hs_clks, lo_clks, line_clks, vs_clks, frame_clks;
   int          av_cnt, act_lines, ref_step, n_vs;
   int          err_count = 0, n_checks = 0, cyc = 0, seed;
   int          v [1:8];
   logic [4:0]  modes [4] = '{5'h05, 5'h0D, 5'h15, 5'h07};

   rstg_raster_sync dut (
      .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .hsync, .vsync, .blank, .cycle_strobe, .addr_valid, .refresh_addr,
      .refresh_cycle, .odd_field, .pixels_per_cycle_ratio
   );
   rstg_crt_model crt (
      .core_clk, .hsync, .vsync, .blank, .addr_valid, .refresh_addr,
      .hs_clks, .lo_clks, .line_clks, .vs_clks, .frame_clks, .av_cnt,
      .act_lines, .ref_step, .n_vs
   );

   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic complete_run;
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // The whole run needs about three thousand cycles, five thousand at most.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %0d seen %0d", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk("rdata", reg_rdata, exp);
   endtask

   task automatic run_cfg(input int m);
      int line, act, base, t;
      v[1] = 2 + $urandom % 3;
      v[2] = 3 + $urandom % 2;
      v[3] = 3 + $urandom % 3;
      v[4] = 2 * (1 + $urandom % 3);
      for (int i = 5; i < 8; i++) v[i] = 1 + $urandom % 2;
      v[8] = 2 + $urandom % 2;
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 1; i < 9; i++) wr(4'(i), 16'(v[i]));
      wr(4'hF, 16'hFFFF);
      rd_chk(4'hF, 16'h0000);
      rd_chk(RSTG_ADDR_STATUS, 16'h1000);
      rd_chk(RSTG_ADDR_REFRESH, 16'h0000);
      for (int i = 1; i < 9; i++) rd_chk(4'(i), 16'(v[i]));
      wr(RSTG_ADDR_CTRL, {11'h000, modes[m]});
      rd_chk(RSTG_ADDR_CTRL, {11'h000, modes[m]});
      chk("ratio", pixels_per_cycle_ratio,
          m == 1 ? 16 : m == 2 ? 4 : 8);
      base = n_vs;
      t = 0;
      while (n_vs < base + 4 && t < 8000) begin
         @(posedge core_clk);
         t++;
      end
      #1;
      chk("fields", n_vs - base, 4);
      chk("odd", odd_field, m == 3);
      act = v[4] * (m == 2 ? 4 : 2);
      line = 2 * (v[1] + v[2] + v[3]) + act;
      chk("hsync", hs_clks, 2 * v[2]);
      chk("active", lo_clks, act);
      chk("line", line_clks, line);
      chk("vsync", vs_clks, v[6] * line);
      chk("frame", frame_clks,
          2 * (v[5] + v[6] + v[7] + v[8]) * line + (m == 3 ? line : 0));
      chk("lines", act_lines, v[8]);
      chk("addr", av_cnt, m == 2 ? 2 * v[4] : v[4]);
      chk("refresh", ref_step, v[2]);
   endtask

   initial begin
      seed = $urandom(31);
      for (int m = 0; m < 4; m++) run_cfg(m);
      complete_run();
   end
endmodule
